// *** bench/tbr_ram_model.sv ***
// Behavioural trace RAM facing the register bank: one strobe port, read answer a cycle later.
// Assumes single-cycle registered strobes from the bank in the same clock domain.
`timescale 1ns/1ps
module tbr_ram_model (
  // Clock
  input wire logic i_mclk,
  // Strobes from the bank
  input wire logic i_cs,
  input wire logic i_we,
  input wire logic [tbr_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  // Read answer
  output logic [31:0] o_rdata
);
  logic [31:0] mem_q [1024];
  initial o_rdata = 32'h0;
  always_ff @(posedge i_mclk) begin
    if (i_cs && i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
    // Stale data is inverted so a late sample cannot match by luck
    o_rdata <= (i_cs && !i_we) ? mem_q[i_addr] : ~o_rdata;
  end
endmodule

// *** bench/tbr_regs_bench.sv ***
// Self-checking bench for the trace buffer register bank.
// Assumes requests from scan or AHB side already in the core clock domain.
`timescale 1ns/1ps
module tbr_regs_bench;
  logic i_mclk, i_rst, i_intest, i_fmt_idle, o_rvalid, o_word_ready, o_ram_cs, o_ram_we;
  logic o_capture_enable, o_demux, o_bus_access_select, o_read_address_updated, got_ok;
  logic i_ce, got_upd;
  tbr_pkg::tbr_req_type i_req;
  tbr_pkg::tbr_word_type i_word;
  logic [31:0] o_rdata, ram_rdata, o_ram_wdata, got;
  logic [tbr_pkg::ADDR_W-1:0] o_ram_addr;
  int failures = 0;
  int total_checks = 0;

  tbr_regs tbr_regs_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_req(i_req),
    .i_intest(i_intest), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .i_word(i_word),
    .o_word_ready(o_word_ready), .i_fmt_idle(i_fmt_idle), .i_ram_rdata(ram_rdata),
    .o_ram_cs(o_ram_cs), .o_ram_we(o_ram_we), .o_ram_addr(o_ram_addr),
    .o_ram_wdata(o_ram_wdata), .o_capture_enable(o_capture_enable), .o_demux(o_demux),
    .o_bus_access_select(o_bus_access_select),
    .o_read_address_updated(o_read_address_updated));
  tbr_ram_model tbr_ram_model_inst (.i_mclk(i_mclk), .i_cs(o_ram_cs), .i_we(o_ram_we),
    .i_addr(o_ram_addr), .i_wdata(o_ram_wdata), .o_rdata(ram_rdata));

  // ****************
  // Helpers
  // ****************
  task automatic chk32(input logic [31:0] act, input logic [31:0] exp);
    total_checks++;
    if (act !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic chk1(input logic act, input logic exp);
    chk32({31'h0, act}, {31'h0, exp});
  endtask
  // One request pulse, then three cycles watching for the answer; keeps readout spacing
  task automatic req(input logic wr, input logic scan, input logic [6:0] sel,
                     input logic [31:0] d);
    @(posedge i_mclk) #1;
    i_req = '{valid: 1'b1, write: wr, from_scan: scan, sel: sel, wdata: d};
    @(posedge i_mclk) #1;
    i_req.valid = 1'b0;
    got_ok = 1'b0;
    got_upd = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (!wr && !got_ok && o_rvalid === 1'b1) begin
        got_ok = 1'b1;
        got = o_rdata;
      end
      if (o_read_address_updated === 1'b1) begin
        got_upd = 1'b1;
      end
      @(posedge i_mclk) #1;
    end
  endtask
  task automatic rd(input logic scan, input logic [6:0] sel, input logic [31:0] exp);
    req(1'b0, scan, sel, 32'h0);
    chk1(got_ok, 1'b1);
    chk32(got, exp);
  endtask
  task automatic push(input logic [23:0] d, input logic trg);
    chk1(o_word_ready, 1'b1);
    i_word = '{valid: 1'b1, data: d, trigger: trg};
    @(posedge i_mclk) #1;
    i_word.valid = 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    rd(1'b1, tbr_pkg::SEL_ID, tbr_pkg::ID_CONSTANT);
    rd(1'b1, tbr_pkg::SEL_COUNT, tbr_pkg::ENTRY_COUNT);
    rd(1'b1, tbr_pkg::SEL_WIDTH, {26'h0, tbr_pkg::ENTRY_BITS_24});
    rd(1'b1, tbr_pkg::SEL_STATUS, 32'h4);
    rd(1'b1, tbr_pkg::SEL_CTRL, 32'h4);
    for (int s = 5; s < 8; s++) rd(1'b1, 7'(s), 32'h0);
    rd(1'b1, 7'h09, 32'h0);
    rd(1'b1, 7'h7f, 32'h0);
    chk1(o_capture_enable, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_capture();
    req(1'b1, 1'b1, tbr_pkg::SEL_WPTR, 32'h3fe);
    req(1'b1, 1'b1, tbr_pkg::SEL_TRIG, 32'h2);
    req(1'b1, 1'b1, tbr_pkg::SEL_CTRL, 32'h1);
    chk1(o_capture_enable, 1'b1);
    req(1'b1, 1'b1, tbr_pkg::SEL_WPTR, 32'h10);
    req(1'b1, 1'b1, tbr_pkg::SEL_TRIG, 32'h10);
    req(1'b1, 1'b1, tbr_pkg::SEL_RPTR, 32'h10);
    chk1(got_upd, 1'b0);
    // Trigger is the third word; the readout word is left alone while capturing
    for (int i = 0; i < 8; i++) push(24'ha00000 + 24'(i), i == 2);
    rd(1'b1, tbr_pkg::SEL_STATUS, 32'h7);
    req(1'b1, 1'b1, tbr_pkg::SEL_CTRL, 32'h0);
    i_fmt_idle = 1'b1;
    rd(1'b1, tbr_pkg::SEL_STATUS, 32'hf);
    rd(1'b1, tbr_pkg::SEL_WPTR, 32'h4);
    rd(1'b1, tbr_pkg::SEL_TRIG, 32'h0);
    rd(1'b1, tbr_pkg::SEL_RPTR, 32'h0);
    $display("test capture done");
  endtask
  task automatic t_readout();
    req(1'b1, 1'b1, tbr_pkg::SEL_RPTR, 32'h3fe);
    chk1(got_upd, 1'b1);
    rd(1'b1, tbr_pkg::SEL_READOUT, 32'h00a0_0000);
    rd(1'b1, tbr_pkg::SEL_RPTR, 32'h3ff);
    rd(1'b0, tbr_pkg::SEL_READOUT, 32'h00a0_0001);
    rd(1'b1, tbr_pkg::SEL_READOUT, 32'h00a0_0002);
    $display("test readout done");
  endtask
  task automatic t_reenable();
    req(1'b1, 1'b1, tbr_pkg::SEL_TRIG, 32'h5);
    i_fmt_idle = 1'b0;
    req(1'b1, 1'b1, tbr_pkg::SEL_CTRL, 32'h1);
    rd(1'b1, tbr_pkg::SEL_STATUS, 32'h0);
    req(1'b1, 1'b1, tbr_pkg::SEL_CTRL, 32'h0);
    $display("test reenable done");
  endtask
  task automatic t_bus_sel();
    req(1'b1, 1'b0, tbr_pkg::SEL_CTRL, 32'h6);
    rd(1'b0, tbr_pkg::SEL_CTRL, 32'h6);
    chk1(o_demux, 1'b1);
    i_intest = 1'b1;
    @(posedge i_mclk) #1;
    i_intest = 1'b0;
    @(posedge i_mclk) #1;
    chk1(o_bus_access_select, 1'b0);
    req(1'b0, 1'b0, tbr_pkg::SEL_ID, 32'h0);
    chk1(got_ok, 1'b0);
    req(1'b1, 1'b0, tbr_pkg::SEL_CTRL, 32'h0);
    rd(1'b1, tbr_pkg::SEL_CTRL, 32'h2);
    req(1'b1, 1'b1, tbr_pkg::SEL_CTRL, 32'h4);
    rd(1'b0, tbr_pkg::SEL_CTRL, 32'h4);
    $display("test bus select done");
  endtask
  // A write while the clock enable is low must not land
  task automatic t_freeze();
    i_ce = 1'b0;
    req(1'b1, 1'b1, tbr_pkg::SEL_TRIG, 32'h3);
    i_ce = 1'b1;
    rd(1'b1, tbr_pkg::SEL_TRIG, 32'h5);
    $display("test freeze done");
  endtask

  task automatic test_done();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    failures++;
    test_done();
  end
  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_intest = 1'b0;
    i_fmt_idle = 1'b0;
    i_req = '0;
    i_word = '0;
    repeat (6) @(posedge i_mclk);
    #1;
    i_rst = 1'b0;
    t_reset();
    t_capture();
    t_readout();
    t_reenable();
    t_bus_sel();
    t_freeze();
    test_done();
  end
endmodule

// *** pkg/tbr_pkg.sv ***
// Package for the trace buffer register bank: selectors, fields, reset values, carriers.
// Assumes one core clock domain; the scan and AHB sides are already synchronised.
package tbr_pkg;

  // ******************************
  // Geometry
  // ******************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 24;
  localparam logic [31:0] ENTRY_COUNT = 32'h0000_0400;
  localparam logic [5:0] ENTRY_BITS_24 = 6'h18;
  localparam logic [5:0] ENTRY_BITS_32 = 6'h20;
  // Arbitrary neutral identification value
  localparam logic [31:0] ID_CONSTANT = 32'h5a5a_0001;
  localparam int FIFO_DEPTH = 8;

  // ******************************
  // Register selectors
  // ******************************
  localparam logic [6:0] SEL_ID = 7'h00;
  localparam logic [6:0] SEL_COUNT = 7'h01;
  localparam logic [6:0] SEL_WIDTH = 7'h02;
  localparam logic [6:0] SEL_STATUS = 7'h03;
  localparam logic [6:0] SEL_READOUT = 7'h04;
  localparam logic [6:0] SEL_RPTR = 7'h05;
  localparam logic [6:0] SEL_WPTR = 7'h06;
  localparam logic [6:0] SEL_TRIG = 7'h07;
  localparam logic [6:0] SEL_CTRL = 7'h08;

  // ******************************
  // Field positions and resets
  // ******************************
  localparam int CTRL_CAPTURE = 0;
  localparam int CTRL_DEMUX = 1;
  localparam int CTRL_BUS_SEL = 2;
  localparam int ST_FULL = 0;
  localparam int ST_TRIG = 1;
  localparam int ST_DONE = 2;
  localparam int ST_DRAINED = 3;
  localparam logic RST_BUS_SEL = 1'b1;

  typedef struct packed {
    logic valid;
    logic write;
    logic from_scan;
    logic [6:0] sel;
    logic [31:0] wdata;
  } tbr_req_type;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
    logic trigger;
  } tbr_word_type;

endpackage

// *** rtl/tbr_fifo.sv ***
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; push and pop may happen in the same cycle.
`timescale 1ns/1ps
module tbr_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wp_q, rp_q;
  logic push, pop;

  assign o_ready = (wp_q - rp_q) != (PW+1)'(DEPTH);
  assign o_valid = wp_q != rp_q;
  assign o_data = mem[rp_q[PW-1:0]];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (i_ce) begin
      if (push) begin
        mem[wp_q[PW-1:0]] <= i_data;
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

// *** rtl/tbr_regs.sv ***
// Register bank of the trace capture buffer, with capture pointer logic.
// Assumes requests are one-cycle pulses already in this clock domain and
// the trace RAM returns read data one cycle after its address.
//
// Behaviour
// - All register bits reset to zero except the bus access select bit and status bit 2 (counter at zero).
// - Selectors 0 to 8 are decoded; 9 to 127 read zero, writes ignored.
// - Register 0 returns a fixed 32-bit identification constant.
// - Register 1 returns the fixed number of RAM entries.
// - Register 2 returns entry width in bits 5:0; always 24.
// - Status bit 3 shows formatter pipeline drained after capture stops.
// - Status bit 2 shows post-trigger counter reached zero.
// - Status bit 1 sets when a trigger word arrives.
// - Status bit 0 sets when capture pointer wraps to zero.
// - All status flags except bit 2 clear in the cycle capture becomes enabled.
// - Readout read returns RAM word; with capture off it also bumps read pointer, starts new access.
// - Read pointer write loads it and raises read address updated.
// - Pointer and counter writes are blocked while capture is enabled.
// - Capture pointer advances per valid formatter word during capture.
// - After trigger, store post-trigger count plus one words then stop.
// - Control bit 0 drives capture enable and RAM write mode.
// - Control bit 1 selects demultiplexed memory support.
// - Bus select bit resets to one, scan-only; zero blocks AHB access.
`timescale 1ns/1ps
module tbr_regs (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Register request and answer
  input wire tbr_pkg::tbr_req_type i_req,
  input wire logic i_intest,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  // Formatter stream
  input wire tbr_pkg::tbr_word_type i_word,
  output logic o_word_ready,
  input wire logic i_fmt_idle,
  // Trace RAM
  input wire logic [31:0] i_ram_rdata,
  output logic o_ram_cs,
  output logic o_ram_we,
  output logic [tbr_pkg::ADDR_W-1:0] o_ram_addr,
  output logic [31:0] o_ram_wdata,
  // Control outputs
  output logic o_capture_enable,
  output logic o_demux,
  output logic o_bus_access_select,
  output logic o_read_address_updated
);
  localparam int AW = tbr_pkg::ADDR_W;

  // ******************************
  // State
  // ******************************
  typedef struct packed {
    logic cap;
    logic demux;
    logic bus_sel;
    logic [AW-1:0] rptr;
    logic [AW-1:0] wptr;
    logic [AW-1:0] tcnt;
    logic full;
    logic trig;
    logic stopped;
    logic rvalid;
    logic [31:0] rdata;
    logic ram_cs;
    logic ram_we;
    logic [AW-1:0] ram_addr;
    logic [31:0] ram_wdata;
    logic rd_upd;
    logic rd_wait;
    logic [31:0] hold;
  } tbr_state_type;

  tbr_state_type s_q, s_d;
  logic f_valid, f_ready, f_trig;
  logic [tbr_pkg::DATA_W-1:0] f_data;
  logic acc, wr, rd, locked, store;

  function automatic logic [31:0] zext(input logic [AW-1:0] v);
    zext = {{(32-AW){1'b0}}, v};
  endfunction

  // ******************************
  // Stream buffer
  // ******************************
  // Words queue here while capture is disabled; a full queue stalls the formatter.
  tbr_fifo #(
    .WIDTH(tbr_pkg::DATA_W + 1),
    .DEPTH(tbr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_valid(i_word.valid),
    .i_data({i_word.trigger, i_word.data}),
    .o_ready(o_word_ready),
    .o_valid(f_valid),
    .o_data({f_trig, f_data}),
    .i_ready(f_ready)
  );

  // ******************************
  // Next state
  // ******************************
  always_comb begin
    s_d = s_q;
    acc = i_req.valid && (i_req.from_scan || s_q.bus_sel);
    wr = acc && i_req.write;
    rd = acc && !i_req.write;
    locked = s_q.cap;
    f_ready = s_q.cap;
    store = f_valid && s_q.cap && !s_q.stopped;
    s_d.rvalid = rd;
    s_d.ram_cs = 1'b0;
    s_d.ram_we = 1'b0;
    s_d.rd_upd = 1'b0;
    if (rd) begin
      unique case (i_req.sel)
        tbr_pkg::SEL_ID: s_d.rdata = tbr_pkg::ID_CONSTANT;
        tbr_pkg::SEL_COUNT: s_d.rdata = tbr_pkg::ENTRY_COUNT;
        tbr_pkg::SEL_WIDTH: s_d.rdata = {26'h0, tbr_pkg::ENTRY_BITS_24};
        tbr_pkg::SEL_STATUS: s_d.rdata = {28'h0, (!s_q.cap && i_fmt_idle),
            (s_q.tcnt == '0), s_q.trig, s_q.full};
        tbr_pkg::SEL_READOUT: begin
          // Data prefetched at the read pointer; the pointer bumps now, the next word's RAM fetch goes out a cycle later
          s_d.rdata = {8'h00, s_q.hold[tbr_pkg::DATA_W-1:0]};
          if (!s_q.cap) begin
            s_d.rptr = s_q.rptr + 1'b1;
            s_d.rd_upd = 1'b1;
          end
        end
        tbr_pkg::SEL_RPTR: s_d.rdata = zext(s_q.rptr);
        tbr_pkg::SEL_WPTR: s_d.rdata = zext(s_q.wptr);
        tbr_pkg::SEL_TRIG: s_d.rdata = zext(s_q.tcnt);
        tbr_pkg::SEL_CTRL: s_d.rdata = {29'h0, s_q.bus_sel, s_q.demux, s_q.cap};
        default: s_d.rdata = 32'h0;
      endcase
    end
    if (wr) begin
      unique case (i_req.sel)
        tbr_pkg::SEL_RPTR: begin
          if (!locked) begin
            s_d.rptr = i_req.wdata[AW-1:0];
            s_d.rd_upd = 1'b1;
          end
        end
        tbr_pkg::SEL_WPTR: begin
          if (!locked) begin
            s_d.wptr = i_req.wdata[AW-1:0];
          end
        end
        tbr_pkg::SEL_TRIG: begin
          if (!locked) begin
            s_d.tcnt = i_req.wdata[AW-1:0];
          end
        end
        tbr_pkg::SEL_CTRL: begin
          s_d.cap = i_req.wdata[tbr_pkg::CTRL_CAPTURE];
          s_d.demux = i_req.wdata[tbr_pkg::CTRL_DEMUX];
          if (i_req.from_scan && i_req.wdata[tbr_pkg::CTRL_BUS_SEL]) begin
            s_d.bus_sel = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (store) begin
      s_d.ram_cs = 1'b1;
      s_d.ram_we = 1'b1;
      s_d.ram_addr = s_q.wptr;
      s_d.ram_wdata = {8'h00, f_data};
      s_d.wptr = s_q.wptr + 1'b1;
      if (s_q.wptr == '1) begin
        s_d.full = 1'b1;
      end
      if (f_trig) begin
        s_d.trig = 1'b1;
      end
      if (s_q.trig) begin
        // Trigger word is not counted; count plus one words follow it
        if (s_q.tcnt == '0) begin
          s_d.stopped = 1'b1;
        end else begin
          s_d.tcnt = s_q.tcnt - 1'b1;
        end
      end
    end else if (s_q.rd_upd) begin
      s_d.ram_cs = 1'b1;
      s_d.ram_addr = s_q.rptr;
    end
    // RAM takes the strobe on the next edge; its data stands a cycle after that
    s_d.rd_wait = s_q.ram_cs && !s_q.ram_we;
    if (s_q.rd_wait) begin
      s_d.hold = i_ram_rdata;
    end
    if (i_intest) begin
      s_d.bus_sel = 1'b0;
    end
    if (s_d.cap && !s_q.cap) begin
      s_d.full = 1'b0;
      s_d.trig = 1'b0;
      s_d.stopped = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.bus_sel <= tbr_pkg::RST_BUS_SEL;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_rvalid = s_q.rvalid;
  assign o_rdata = s_q.rdata;
  assign o_ram_cs = s_q.ram_cs;
  assign o_ram_we = s_q.ram_we;
  assign o_ram_addr = s_q.ram_addr;
  assign o_ram_wdata = s_q.ram_wdata;
  assign o_capture_enable = s_q.cap;
  assign o_demux = s_q.demux;
  assign o_bus_access_select = s_q.bus_sel;
  assign o_read_address_updated = s_q.rd_upd;

  // ******************************
  // Checks
  // ******************************
  AST_BUS_BLOCK: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && i_req.valid && !i_req.from_scan && !s_q.bus_sel) |=> !o_rvalid)
    else $error("bus access taken while blocked");
  AST_LOCK: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && s_q.cap && !store && !rd) |=> $stable(s_q.wptr) && $stable(s_q.tcnt)
      && $stable(s_q.rptr))
    else $error("pointer changed while locked");
  AST_CLEAR: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && $rose(s_q.cap)) |-> !s_q.full && !s_q.trig)
    else $error("status not cleared on enable");
  AST_WRAP: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && store && s_q.wptr == '1 && !(s_d.cap && !s_q.cap)) |=> s_q.full)
    else $error("wrap did not set full");
  AST_ADV: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && store && !wr) |=> s_q.wptr == $past(s_q.wptr) + 1'b1)
    else $error("pointer did not advance");
  AST_STOP: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_q.stopped |-> !o_ram_we || $past(store))
    else $error("write after stop");
  AST_RPTR: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && wr && i_req.sel == tbr_pkg::SEL_RPTR && !s_q.cap) |=> o_read_address_updated)
    else $error("read address update missing");
  AST_ID: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && rd && i_req.sel == tbr_pkg::SEL_ID) |=> o_rdata == tbr_pkg::ID_CONSTANT)
    else $error("bad id word");
  AST_RESERVED: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && rd && i_req.sel > tbr_pkg::SEL_CTRL) |=> o_rdata == 32'h0)
    else $error("reserved selector read not zero");
  AST_WIDTH: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && rd && i_req.sel == tbr_pkg::SEL_WIDTH) |=>
      o_rdata == {26'h0, tbr_pkg::ENTRY_BITS_24})
    else $error("bad entry width word");
  AST_DRAIN_OFF: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && rd && i_req.sel == tbr_pkg::SEL_STATUS && s_q.cap) |=>
      !o_rdata[tbr_pkg::ST_DRAINED])
    else $error("drained shown during capture");
  AST_INTEST: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && i_intest) |=> !o_bus_access_select)
    else $error("bus select not cleared by intest");

  // ******************************
  // Fetch sequences
  // ******************************
  // Both steps need the enable high, or the fetch is legally postponed
  sequence seq_readout_take;
    (i_ce && rd && i_req.sel == tbr_pkg::SEL_READOUT && !s_q.cap) ##1 i_ce;
  endsequence
  sequence seq_rptr_load;
    (i_ce && wr && i_req.sel == tbr_pkg::SEL_RPTR && !s_q.cap) ##1 i_ce;
  endsequence
  sequence seq_ram_fetch;
    o_read_address_updated ##1 (o_ram_cs && !o_ram_we && o_ram_addr == $past(s_q.rptr));
  endsequence
  AST_READOUT: assert property (@(posedge i_mclk) disable iff (i_rst)
    seq_readout_take |-> seq_ram_fetch)
    else $error("readout did not start a RAM fetch");
  AST_RPTR_FETCH: assert property (@(posedge i_mclk) disable iff (i_rst)
    seq_rptr_load |-> seq_ram_fetch)
    else $error("pointer load did not start a RAM fetch");
endmodule
